/* File: design/muxed_async_memory_read_port.sv */
/*
 * Read engine for a multiplexed address/data parallel port, with an
 * AXI4-Lite register slave and a 4-word read-data FIFO.
 * Assumes bus_in is synchronous to sys_clk and the peripheral clock is sys_clk.
 */
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module muxed_async_memory_read_port (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] bus_in,
    output logic [15:0] bus_out,
    output logic bus_oe_hi,
    output logic bus_oe_lo,
    output logic ale,
    output logic rd_n
);
    logic rst_meta_q;
    logic rst_sync_q;
    mux_read_pkg::ctrl_t ctrl_q;
    logic [15:0] base_q;
    logic [15:0] count_q;
    mux_read_pkg::state_t state_q;
    logic [15:0] ext_addr_q;
    logic [15:0] left_q;
    logic [2:0] idx_q;
    logic [4:0] cnt_q;
    mux_read_pkg::pins_t pins_q;
    mux_read_pkg::pins_t pins_d;
    logic [2:0] per_group;
    logic [4:0] dur_cycles;
    logic [4:0] hold_cycles;
    logic last_strobe;
    logic busy;
    logic capture;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [15:0] fifo_out_data;
    logic [15:0] sample;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic start;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;

    // Reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign busy = (state_q != mux_read_pkg::ST_IDLE);
    assign ctrl_word = {21'h000000, ctrl_q[mux_read_pkg::CTRL_W-1:1], 1'b0};
    assign status_word = {left_q, 13'h0000, !fifo_in_ready, fifo_out_valid, busy};

    // Group size by memory width and packing
    always_comb begin
        if (!ctrl_q.wide) begin
            per_group = mux_read_pkg::STROBES_8BIT;
        end else if (ctrl_q.packing_nz) begin
            per_group = mux_read_pkg::STROBES_16_PACKED;
        end else begin
            per_group = mux_read_pkg::STROBES_16_UNPACKED;
        end
    end

    // A zero duration would wrap the counter into a 32-clock strobe, so it acts as one clock
    assign dur_cycles = (ctrl_q.dur == 5'h00) ? 5'h01 : ctrl_q.dur;
    assign hold_cycles = ctrl_q.hold ? mux_read_pkg::HOLD_CYCLES : 5'h00;
    assign last_strobe = (idx_q == per_group - 3'h1);

    // AXI4-Lite write channels: address and data taken in either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign start = do_write && !busy && (aw_addr_q == mux_read_pkg::OFS_CTRL)
        && w_strb_q[0] && w_data_q[mux_read_pkg::CTRL_GO_BIT];

    always_ff @(posedge sys_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mux_read_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q)
                    mux_read_pkg::OFS_CTRL, mux_read_pkg::OFS_BASE, mux_read_pkg::OFS_COUNT,
                    mux_read_pkg::OFS_DATA, mux_read_pkg::OFS_STATUS: begin
                        s_axi_bresp <= mux_read_pkg::RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= mux_read_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Settings are frozen while a transfer runs so counters never see a change mid-strobe
    always_ff @(posedge sys_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ctrl_q <= mux_read_pkg::CTRL_RESET;
            base_q <= mux_read_pkg::BASE_RESET;
            count_q <= mux_read_pkg::COUNT_RESET;
        end else if (do_write && !busy) begin
            case (aw_addr_q)
                mux_read_pkg::OFS_CTRL: begin
                    ctrl_q <= mux_read_pkg::CTRL_W'(merge(ctrl_word, w_data_q, w_strb_q) & 32'h000007fe);
                end
                mux_read_pkg::OFS_BASE: begin
                    base_q <= 16'(merge({16'h0000, base_q}, w_data_q, w_strb_q));
                end
                mux_read_pkg::OFS_COUNT: begin
                    count_q <= 16'(merge({16'h0000, count_q}, w_data_q, w_strb_q));
                end
                default: begin
                end
            endcase
        end
    end

    // AXI4-Lite read channel; reading the data register pops the FIFO
    assign s_axi_arready = !s_axi_rvalid;
    assign fifo_pop = s_axi_arvalid && s_axi_arready && (s_axi_araddr == mux_read_pkg::OFS_DATA);

    always_ff @(posedge sys_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= mux_read_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mux_read_pkg::RESP_OKAY;
            case (s_axi_araddr)
                mux_read_pkg::OFS_CTRL: s_axi_rdata <= ctrl_word;
                mux_read_pkg::OFS_BASE: s_axi_rdata <= {16'h0000, base_q};
                mux_read_pkg::OFS_COUNT: s_axi_rdata <= {16'h0000, count_q};
                mux_read_pkg::OFS_DATA: s_axi_rdata <= fifo_out_valid ? {16'h0000, fifo_out_data} : 32'h00000000;
                mux_read_pkg::OFS_STATUS: s_axi_rdata <= status_word;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= mux_read_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Pin sequencer
    always_ff @(posedge sys_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= mux_read_pkg::ST_IDLE;
            ext_addr_q <= 16'h0000;
            left_q <= 16'h0000;
            idx_q <= 3'h0;
            cnt_q <= 5'h00;
        end else begin
            case (state_q)
                mux_read_pkg::ST_IDLE: begin
                    if (start && count_q != 16'h0000) begin
                        ext_addr_q <= base_q;
                        left_q <= count_q;
                        idx_q <= 3'h0;
                        cnt_q <= mux_read_pkg::ALE_CYCLES - 5'h01;
                        state_q <= mux_read_pkg::ST_LATCH;
                    end
                end
                mux_read_pkg::ST_LATCH: begin
                    if (cnt_q == 5'h00) begin
                        state_q <= mux_read_pkg::ST_ADDR_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                mux_read_pkg::ST_ADDR_HOLD: begin
                    state_q <= mux_read_pkg::ST_TURN;
                end
                mux_read_pkg::ST_TURN: begin
                    // A strobe starts only with FIFO room, so its datum is never dropped
                    if (fifo_in_ready) begin
                        cnt_q <= dur_cycles - 5'h01;
                        state_q <= mux_read_pkg::ST_STROBE;
                    end
                end
                mux_read_pkg::ST_STROBE: begin
                    if (cnt_q == 5'h00) begin
                        if (last_strobe && ctrl_q.flash) begin
                            cnt_q <= hold_cycles + mux_read_pkg::FLASH_CYCLES;
                        end else begin
                            cnt_q <= hold_cycles;
                        end
                        state_q <= mux_read_pkg::ST_RECOVER;
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                mux_read_pkg::ST_RECOVER: begin
                    if (cnt_q != 5'h00) begin
                        cnt_q <= cnt_q - 5'h01;
                    end else if (!last_strobe) begin
                        idx_q <= idx_q + 3'h1;
                        state_q <= mux_read_pkg::ST_TURN;
                    end else begin
                        idx_q <= 3'h0;
                        ext_addr_q <= ext_addr_q + {13'h0000, per_group};
                        left_q <= left_q - 16'h0001;
                        cnt_q <= mux_read_pkg::ALE_CYCLES - 5'h01;
                        state_q <= (left_q == 16'h0001) ? mux_read_pkg::ST_IDLE : mux_read_pkg::ST_LATCH;
                    end
                end
                default: begin
                    state_q <= mux_read_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Pin levels decoded from the state, then registered so the pins never glitch
    always_comb begin
        pins_d.ale = ctrl_q.ale_low;
        pins_d.rd_n = 1'b1;
        pins_d.oe_hi = 1'b0;
        pins_d.oe_lo = 1'b0;
        pins_d.dout = ext_addr_q;
        case (state_q)
            mux_read_pkg::ST_LATCH: begin
                pins_d.ale = !ctrl_q.ale_low;
                pins_d.oe_hi = 1'b1;
                pins_d.oe_lo = 1'b1;
            end
            mux_read_pkg::ST_ADDR_HOLD: begin
                pins_d.oe_hi = 1'b1;
                pins_d.oe_lo = 1'b1;
            end
            mux_read_pkg::ST_TURN: begin
                pins_d.oe_hi = !ctrl_q.wide;
            end
            mux_read_pkg::ST_STROBE: begin
                pins_d.rd_n = 1'b0;
                pins_d.oe_hi = !ctrl_q.wide;
            end
            mux_read_pkg::ST_RECOVER: begin
                pins_d.oe_hi = !ctrl_q.wide;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pins_q <= '{ale: 1'b0, rd_n: 1'b1, oe_hi: 1'b0, oe_lo: 1'b0, dout: 16'h0000};
        end else begin
            pins_q <= pins_d;
        end
    end

    assign ale = pins_q.ale;
    assign rd_n = pins_q.rd_n;
    assign bus_oe_hi = pins_q.oe_hi;
    assign bus_oe_lo = pins_q.oe_lo;
    assign bus_out = pins_q.dout;

    // Data is taken on the edge that raises the read strobe pin
    assign capture = !pins_q.rd_n && !pins_d.rd_n ? 1'b0 : !pins_q.rd_n;
    assign sample = ctrl_q.wide ? bus_in : {8'h00, bus_in[7:0]};

    word_fifo #(
        .WIDTH(mux_read_pkg::DATA_W),
        .DEPTH(mux_read_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(sys_clk),
        .rst_n(rst_sync_q),
        .in_valid(capture),
        .in_ready(fifo_in_ready),
        .in_data(sample),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );
endmodule

/* File: design/mux_read_pkg.sv */
/*
 * Shared constants and types for the multiplexed address/data read port:
 * register map, control field layout, reset values, strobe timing counts.
 * Assumes the peripheral clock equals the 125 MHz system clock.
 */
package mux_read_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BASE = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Control field positions
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_DUR_LSB = 1;
    localparam int CTRL_W = 11;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h002;
    localparam logic [15:0] BASE_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // Status field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NEMPTY_BIT = 1;
    localparam int STAT_FULL_BIT = 2;
    localparam int STAT_LEFT_LSB = 16;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing, in peripheral clock periods, and the clock rate
    localparam int SYS_CLK_PERIOD_NS = 8;
    localparam int PCLK_PERIOD_NS = 8;
    localparam int PCLK_PER_SYS = PCLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
    localparam int ALE_WIDTH_PCLK = 2;
    localparam int FLASH_EXTRA_PCLK = 7;
    localparam logic [4:0] ALE_CYCLES = 5'(ALE_WIDTH_PCLK * PCLK_PER_SYS);
    localparam logic [4:0] FLASH_CYCLES = 5'(FLASH_EXTRA_PCLK * PCLK_PER_SYS);
    localparam logic [4:0] HOLD_CYCLES = 5'(PCLK_PER_SYS);

    // Read strobes per address latch cycle
    localparam logic [2:0] STROBES_8BIT = 3'h4;
    localparam logic [2:0] STROBES_16_UNPACKED = 3'h2;
    localparam logic [2:0] STROBES_16_PACKED = 3'h1;

    localparam int FIFO_DEPTH = 4;
    localparam int DATA_W = 16;

    typedef struct packed {
        logic ale_low;
        logic packing_nz;
        logic wide;
        logic flash;
        logic hold;
        logic [4:0] dur;
        logic go;
    } ctrl_t;

    typedef struct packed {
        logic ale;
        logic rd_n;
        logic oe_hi;
        logic oe_lo;
        logic [15:0] dout;
    } pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LATCH,
        ST_ADDR_HOLD,
        ST_TURN,
        ST_STROBE,
        ST_RECOVER
    } state_t;
endpackage

/* File: design/word_fifo.sv */
/*
 * Small synchronous FIFO in flip-flops, valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset already synchronised.
 */
`timescale 1ns/10ps
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

/* File: verification/mux_read_chk.sv */
/* Pin timing assertions for the read port, bound to its top module.
   Assumes CTRL is written with address and data in one beat. */
`timescale 1ns/10ps
module mux_read_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [15:0] bus_out,
    input wire logic bus_oe_hi,
    input wire logic bus_oe_lo,
    input wire logic ale,
    input wire logic rd_n
);
    logic [10:0] ctrl_q;
    logic [4:0] lo_q;
    logic [4:0] hi_q;
    logic [4:0] exp_d;
    logic [4:0] gap;
    logic wr;
    assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h00;
    // A zero duration still gives a one-clock strobe
    assign exp_d = (ctrl_q[5:1] == 5'h00) ? 5'h01 : ctrl_q[5:1];
    assign gap = 5'h01 + 5'(ctrl_q[6]) + (ctrl_q[7] ? 5'h07 : 5'h00);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= mux_read_pkg::CTRL_RESET;
        end else if (wr) begin
            if (s_axi_wstrb[0]) ctrl_q[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) ctrl_q[10:8] <= s_axi_wdata[10:8];
        end
    end
    // The high-time count hi_q saturates, so a long idle never wraps into a false short gap
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_q <= 5'h00;
            hi_q <= 5'h1f;
        end else begin
            lo_q <= rd_n ? 5'h00 : lo_q + 5'h01;
            hi_q <= !rd_n ? 5'h00 : (hi_q == 5'h1f ? hi_q : hi_q + 5'h01);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_strobe_width: assert property ($rose(rd_n) |-> lo_q == exp_d)
        else $error("read strobe width wrong");
    chk_strobe_gap: assert property ($rose(rd_n) |-> rd_n ##1 rd_n ##1 (rd_n || !ctrl_q[6]))
        else $error("read strobe gap too short");
    chk_latch_wait: assert property ($changed(ale) && ale != $past(ale, 3) && bus_oe_lo |-> hi_q >= gap)
        else $error("latch strobe too soon after read");
    chk_addr_hold: assert property ($changed(ale) && ale == $past(ale, 3) && bus_oe_lo |-> bus_oe_hi && $stable(bus_out))
        else $error("address not held after latch");
    chk_lo_release: assert property ($changed(ale) && ale == $past(ale, 3) && bus_oe_lo |=> !bus_oe_lo && (bus_oe_hi != ctrl_q[8]))
        else $error("low lines not released");
    chk_latch_turn: assert property ($changed(ale) && ale == $past(ale, 3) && bus_oe_lo |-> rd_n ##1 rd_n)
        else $error("read strobe too soon after latch");
    chk_lo_resume: assert property (bus_oe_lo |-> rd_n && hi_q >= gap)
        else $error("low lines driven too early");
    chk_hi_byte: assert property ($rose(rd_n) && $past(bus_oe_hi) |-> bus_oe_hi && $stable(bus_out[15:8]))
        else $error("upper address byte dropped");
endmodule

bind muxed_async_memory_read_port mux_read_chk u_mux_read_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .bus_out(bus_out), .bus_oe_hi(bus_oe_hi),
    .bus_oe_lo(bus_oe_lo), .ale(ale), .rd_n(rd_n)
);

/* File: verification/mem_model.sv */
/* Asynchronous memory with an external address latch.
   Assumes the latch polarity is told to it by the bench. */
`timescale 1ns/10ps
module mem_model #(
    parameter logic [15:0] SCRAMBLE = 16'hc35a
) (
    input wire logic clk,
    input wire logic ale,
    input wire logic ale_low,
    input wire logic rd_n,
    input wire logic oe_hi,
    input wire logic oe_lo,
    input wire logic [15:0] bus_out,
    output logic [15:0] bus_in
);
    logic [15:0] lat_q = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    logic [2:0] k_q = 3'h0;
    logic rd_q = 1'b1;
    logic [15:0] mem_v;
    always_ff @(posedge clk) begin
        rd_q <= rd_n;
        if (ale ^ ale_low) begin
            lat_q <= bus_out;
            k_q <= 3'h0;
        end else if (rd_n && !rd_q) begin
            k_q <= k_q + 3'h1;
        end
        if (!rd_n) last_q <= mem_v;
    end
    // Data valid only while the strobe is low; released lines show a changed value
    assign mem_v = rd_n ? ~last_q : ((lat_q + 16'(k_q)) ^ SCRAMBLE);
    assign bus_in = {oe_hi ? bus_out[15:8] : mem_v[15:8], oe_lo ? bus_out[7:0] : mem_v[7:0]};
endmodule

/* File: verification/tb.sv */
/* Self-checking bench: AXI4-Lite master tasks, a register task and one transfer task run once per scenario.
   Assumes the memory model answers on the multiplexed bus. */
`timescale 1ns/10ps
module tb;
    localparam logic [15:0] SCRAMBLE = 16'hc35a;
    logic sys_clk = 1'b0, rst_n = 1'b0, ale_low = 1'b0, rd_q = 1'b1, act_q = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_oe_hi, bus_oe_lo, ale, rd_n;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] bus_in, bus_out;
    int n_fail = 0, n_tests = 0, n_rd = 0, n_lat = 0;
    muxed_async_memory_read_port u_muxed_async_memory_read_port (
        .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .bus_in(bus_in), .bus_out(bus_out), .bus_oe_hi(bus_oe_hi), .bus_oe_lo(bus_oe_lo), .ale(ale), .rd_n(rd_n)
    );
    mem_model #(.SCRAMBLE(SCRAMBLE)) u_mem_model (
        .clk(sys_clk), .ale(ale), .ale_low(ale_low), .rd_n(rd_n), .oe_hi(bus_oe_hi), .oe_lo(bus_oe_lo),
        .bus_out(bus_out), .bus_in(bus_in)
    );
    initial forever #4 sys_clk = ~sys_clk;
    // Count strobes and latch cycles on settled pins
    always @(negedge sys_clk) begin
        if (rd_q && !rd_n) n_rd++;
        if (!act_q && (ale ^ ale_low)) n_lat++;
        rd_q = rd_n;
        act_q = ale ^ ale_low;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done, ta, tw;
        done = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(negedge sys_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done, ta;
        done = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(negedge sys_clk);
            ta = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge sys_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
        end
    endtask
    task automatic test_regs();
        logic [31:0] d;
        logic [1:0] r;
        check(32'({ale, rd_n, bus_oe_hi, bus_oe_lo}), 32'h4);
        axi_read(mux_read_pkg::OFS_CTRL, d, r);
        check(d, 32'(mux_read_pkg::CTRL_RESET));
        check(32'(r), 32'(mux_read_pkg::RESP_OKAY));
        axi_read(8'h14, d, r);
        check(32'(r), 32'(mux_read_pkg::RESP_SLVERR));
        axi_write(8'h14, 32'h1, r);
        check(32'(r), 32'(mux_read_pkg::RESP_SLVERR));
        axi_read(mux_read_pkg::OFS_DATA, d, r);
        check(d, 32'h0);
    endtask
    // Starts a run, lets the FIFO fill when the run has 4 or more words and the engine stall when it has more, then drains it
    task automatic run_case(input logic [10:0] cfg, input logic [15:0] base, input int count, input int per);
        logic [31:0] d, m;
        logic [15:0] e;
        logic [1:0] r;
        int got, total;
        bit full;
        total = count * per;
        got = 0;
        full = 0;
        m = cfg[8] ? 32'h0000ffff : 32'h000000ff;
        ale_low <= cfg[10];
        axi_write(mux_read_pkg::OFS_BASE, 32'(base), r);
        axi_write(mux_read_pkg::OFS_COUNT, 32'(count), r);
        axi_write(mux_read_pkg::OFS_CTRL, 32'(cfg), r);
        repeat (2) @(posedge sys_clk);
        n_rd = 0;
        n_lat = 0;
        axi_write(mux_read_pkg::OFS_CTRL, 32'(cfg) | 32'h1, r);
        check(32'(r), 32'(mux_read_pkg::RESP_OKAY));
        repeat (200) begin
            axi_read(mux_read_pkg::OFS_STATUS, d, r);
            if (d[2]) full = 1;
            if (d[2] || !d[0]) break;
        end
        check(32'(full), 32'(total >= 4));
        repeat (400) begin
            if (got == total) break;
            axi_read(mux_read_pkg::OFS_STATUS, d, r);
            if (d[1]) begin
                axi_read(mux_read_pkg::OFS_DATA, d, r);
                e = (base + 16'(got)) ^ SCRAMBLE;
                check(d & m, 32'(e) & m);
                got++;
            end
        end
        repeat (50) begin
            axi_read(mux_read_pkg::OFS_STATUS, d, r);
            if (!d[0]) break;
        end
        check(d, 32'h0);
        check(32'(got), 32'(total));
        check(32'(n_rd), 32'(total));
        check(32'(n_lat), 32'(count));
        check(32'(ale), 32'(cfg[10]));
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        test_regs();
        run_case(11'h046, 16'h1230, 2, 4);
        run_case(11'h342, 16'h4000, 3, 1);
        run_case(11'h192, 16'h8ffe, 2, 2);
        run_case(11'h400, 16'h00fc, 1, 4);
        finish_test();
    end
    initial begin
        #400000;
        n_fail++;
        finish_test();
    end
endmodule
